// ===== sepc_defs.vh
// Offsets, field positions, reset value and mode codes of the pin configuration register.
// Assumes inclusion by bare name from the pin control design files.
`ifndef SEPC_DEFS_VH
`define SEPC_DEFS_VH

`define SEPC_ADDR_W 6
`define SEPC_CFG_ADDR 6'h06
`define SEPC_CFG_W 16
`define SEPC_CFG_RESET 16'h0800
`define SEPC_CFG_WR_MASK 16'h1f00

`define SEPC_BIT_MUX_DRIVE 12
`define SEPC_BIT_SYNC_EN 11
`define SEPC_ERR_HI 10
`define SEPC_ERR_LO 9
`define SEPC_BIT_PIN_LEVEL 8

`define SEPC_ERR_OFF 2'h0
`define SEPC_ERR_INPUT 2'h1
`define SEPC_ERR_OPEN_DRAIN 2'h2
`define SEPC_ERR_GP_OUT 2'h3

`define SEPC_MAX_MUX_CHANNELS 3'h4
`define SEPC_SETTLE_W 16

`endif

// ===== sepc_sync2.v
// Two-flop synchroniser for levels that arrive from outside the system clock domain.
// Assumes the input is a slowly changing level; only the second stage is read.
`timescale 1ns/1ps

module sepc_sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b1}}
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage_one;
    reg [WIDTH-1:0] stage_two;

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage_one <= RESET_VALUE;
            stage_two <= RESET_VALUE;
        end else begin
            stage_one <= async_in;
            stage_two <= stage_one;
        end
    end

    assign sync_out = stage_two;

endmodule

// ===== sepc_top.v
// Multi-function pin control: external multiplexer select on the two general-purpose pins,
// and the sync / error / general-purpose output roles of the combined sync/error pin.
// Assumes a channel sequencer, an interface mode register and a status register on the same
// clock; only the sync/error pin comes from outside and is synchronised.
`timescale 1ns/1ps
`include "sepc_defs.vh"

module sepc_top #(
    parameter ERR_BITS = 4,
    parameter SETTLE_W = `SEPC_SETTLE_W
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire [`SEPC_ADDR_W-1:0] reg_addr,
    input wire reg_wr_en,
    input wire [`SEPC_CFG_W-1:0] reg_wr_data,
    output reg [`SEPC_CFG_W-1:0] reg_rd_data,
    input wire alternate_sync_select_select,
    input wire seq_multi_channel,
    input wire [1:0] seq_channel_index,
    input wire seq_switch_due,
    input wire [SETTLE_W-1:0] mux_settle_cycles,
    input wire other_error,
    input wire [ERR_BITS-1:0] status_error_bits,
    input wire sync_err_in,
    output reg sync_err_out,
    output reg sync_err_oe,
    output reg gp_pin_zero_out,
    output reg gp_pin_zero_oe,
    output reg gp_pin_one_out,
    output reg gp_pin_one_oe,
    output reg filter_hold_reset,
    output reg conv_start,
    output reg conv_wait,
    output reg conv_error_flag,
    output reg seq_limit_four
);

    // One-hot states of the channel switch sequencing
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SETTLE = 3'h2;
    localparam [2:0] ST_HOLD = 3'h4;
    localparam [SETTLE_W-1:0] SETTLE_ONE = {{(SETTLE_W-1){1'b0}}, 1'b1};
    localparam [SETTLE_W-1:0] SETTLE_ZERO = {SETTLE_W{1'b0}};

    // True when the error field holds the given role
    function is_err_mode;
        input [1:0] field;
        input [1:0] mode;
        begin
            is_err_mode = (field == mode);
        end
    endfunction

    reg [`SEPC_CFG_W-1:0] pin_function_config;
    reg [2:0] state;
    reg [2:0] next_state;
    reg [SETTLE_W-1:0] settle_count;
    reg [SETTLE_W-1:0] next_settle_count;
    reg next_conv_start;
    // Next values of the registered outputs
    reg [`SEPC_CFG_W-1:0] next_rd_data;
    reg [1:0] next_gp_select;
    reg next_gp_drive;
    reg next_sync_err_out;
    reg next_sync_err_oe;
    reg next_conv_error_flag;
    reg next_filter_hold_reset;

    wire pin_level;
    wire ext_mux_drive_enable;
    wire sync_enable;
    wire [1:0] err_mode;
    wire error_pin_level;
    wire sync_role;
    wire alt_effective;
    wire any_status_error;
    wire cfg_hit;
    wire [`SEPC_CFG_W-1:0] cfg_view;
    wire cfg_write;
    wire settle_wanted;
    wire withhold_start;

    // The pin may be driven by another device, so it is synchronised before use
    sepc_sync2 #(
        .WIDTH(1),
        .RESET_VALUE(1'b1)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .async_in(sync_err_in),
        .sync_out(pin_level)
    );

    // Fields of the configuration register
    assign ext_mux_drive_enable = pin_function_config[`SEPC_BIT_MUX_DRIVE];
    assign sync_enable = pin_function_config[`SEPC_BIT_SYNC_EN];
    assign err_mode = pin_function_config[`SEPC_ERR_HI:`SEPC_ERR_LO];
    assign error_pin_level = pin_function_config[`SEPC_BIT_PIN_LEVEL];
    assign cfg_hit = (reg_addr == `SEPC_CFG_ADDR);
    assign cfg_write = reg_wr_en & cfg_hit;

    // Sync function only owns the pin while no error role is selected
    assign sync_role = sync_enable & is_err_mode(err_mode, `SEPC_ERR_OFF);
    assign alt_effective = sync_role & alternate_sync_select_select & seq_multi_channel;
    assign any_status_error = (|status_error_bits);

    // Settling only matters while the pins really switch an external multiplexer
    assign settle_wanted = ext_mux_drive_enable & (mux_settle_cycles != SETTLE_ZERO);
    // In alternate sync with a multi-channel sequence, a low pin at the channel boundary holds back the next start
    assign withhold_start = alt_effective & ~pin_level;

    // Configuration register; only documented fields are writable
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_function_config <= `SEPC_CFG_RESET;
        end else if (cfg_write) begin
            pin_function_config <= reg_wr_data & `SEPC_CFG_WR_MASK;
        end
    end

    // Read view: pin-level bit shows the written value only in output mode
    assign cfg_view = is_err_mode(err_mode, `SEPC_ERR_GP_OUT) ?
        pin_function_config :
        {pin_function_config[`SEPC_CFG_W-1:`SEPC_BIT_PIN_LEVEL+1], pin_level,
         pin_function_config[`SEPC_BIT_PIN_LEVEL-1:0]};

    // Read data is registered; any other address reads as zero
    always @* begin
        next_rd_data = 16'h0000;
        if (cfg_hit) begin
            next_rd_data = cfg_view & `SEPC_CFG_WR_MASK;
        end
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rd_data <= 16'h0000;
        end else begin
            reg_rd_data <= next_rd_data;
        end
    end

    // External multiplexer select on the general-purpose pins
    always @* begin
        next_gp_select = 2'h0;
        next_gp_drive = 1'b0;
        if (ext_mux_drive_enable) begin
            // Select is taken from the channel slot only; the analog pair stays per channel
            next_gp_select = seq_channel_index;
            next_gp_drive = 1'b1;
        end
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gp_pin_zero_out <= 1'b0;
            gp_pin_zero_oe <= 1'b0;
            gp_pin_one_out <= 1'b0;
            gp_pin_one_oe <= 1'b0;
            seq_limit_four <= 1'b0;
        end else begin
            gp_pin_zero_out <= next_gp_select[0];
            gp_pin_one_out <= next_gp_select[1];
            gp_pin_zero_oe <= next_gp_drive;
            gp_pin_one_oe <= next_gp_drive;
            // Two select pins give four codes, so the sequencer must stay within four
            seq_limit_four <= next_gp_drive;
        end
    end

    // Sync/error pin driver
    always @* begin
        next_sync_err_out = 1'b0;
        next_sync_err_oe = 1'b0;
        case (err_mode)
            `SEPC_ERR_OPEN_DRAIN: begin
                // Only ever pull low; a released pin floats to the shared pull-up
                next_sync_err_out = 1'b0;
                next_sync_err_oe = any_status_error;
            end
            `SEPC_ERR_GP_OUT: begin
                next_sync_err_out = error_pin_level;
                next_sync_err_oe = 1'b1;
            end
            default: begin
                next_sync_err_out = 1'b0;
                next_sync_err_oe = 1'b0;
            end
        endcase
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_err_out <= 1'b0;
            sync_err_oe <= 1'b0;
        end else begin
            sync_err_out <= next_sync_err_out;
            sync_err_oe <= next_sync_err_oe;
        end
    end

    // Conversion error flag and immediate sync hold
    always @* begin
        next_conv_error_flag = other_error;
        if (is_err_mode(err_mode, `SEPC_ERR_INPUT)) begin
            // The error input is active low on the pin
            next_conv_error_flag = other_error | ~pin_level;
        end
        // Alternate sync with a multi-channel sequence never holds the filter; it only withholds starts
        next_filter_hold_reset = sync_role & ~alt_effective & ~pin_level;
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_error_flag <= 1'b0;
            filter_hold_reset <= 1'b0;
        end else begin
            conv_error_flag <= next_conv_error_flag;
            filter_hold_reset <= next_filter_hold_reset;
        end
    end

    // Channel switch sequencing: settle wait, then start or withhold
    always @* begin
        next_state = state;
        next_settle_count = settle_count;
        next_conv_start = 1'b0;
        case (state)
            ST_IDLE: begin
                if (seq_switch_due) begin
                    // The hold is decided only once the select has settled
                    if (settle_wanted) begin
                        next_state = ST_SETTLE;
                        next_settle_count = mux_settle_cycles;
                    end else if (withhold_start) begin
                        next_state = ST_HOLD;
                    end else begin
                        next_conv_start = 1'b1;
                    end
                end
            end
            ST_SETTLE: begin
                if (settle_count == SETTLE_ONE) begin
                    next_settle_count = {SETTLE_W{1'b0}};
                    if (withhold_start) begin
                        next_state = ST_HOLD;
                    end else begin
                        next_state = ST_IDLE;
                        next_conv_start = 1'b1;
                    end
                end else begin
                    next_settle_count = settle_count - SETTLE_ONE;
                end
            end
            ST_HOLD: begin
                // Leaving alternate mode also releases a withheld start
                if (pin_level || !alt_effective) begin
                    next_state = ST_IDLE;
                    next_conv_start = 1'b1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_settle_count = {SETTLE_W{1'b0}};
            end
        endcase
    end

    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            settle_count <= {SETTLE_W{1'b0}};
            conv_start <= 1'b0;
            conv_wait <= 1'b0;
        end else begin
            state <= next_state;
            settle_count <= next_settle_count;
            conv_start <= next_conv_start;
            // Busy follows the next state so it rises in the cycle after the switch
            conv_wait <= (next_state != ST_IDLE);
        end
    end

endmodule

// ===== sepc_checker.sv
// Port assertions for the sync/error and multiplexer pin control.
// Assumes binding to sepc_top; the register view is valid after a read of 0x06.
`timescale 1ns/1ps
module sepc_checker #(
    parameter ERR_BITS = 4
) (
    input wire sys_clk,
    input wire sys_rst,
    input wire [5:0] reg_addr,
    input wire [15:0] reg_rd_data,
    input wire [1:0] seq_channel_index,
    input wire seq_switch_due,
    input wire [ERR_BITS-1:0] status_error_bits,
    input wire sync_err_out,
    input wire sync_err_oe,
    input wire gp_pin_zero_out,
    input wire gp_pin_zero_oe,
    input wire gp_pin_one_out,
    input wire gp_pin_one_oe,
    input wire filter_hold_reset,
    input wire conv_start,
    input wire conv_wait,
    input wire seq_limit_four
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    reg v;
    wire [1:0] m = reg_rd_data[10:9];
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) v <= 1'b0;
        else v <= reg_addr == 6'h06;
    end
    sequence s_pulse;
        !conv_wait ##1 !conv_start;
    endsequence
    chk_resv_zero: assert property (reg_rd_data[15:13] == 3'h0) else $error("reserved set");
    chk_unmapped_zero: assert property (!v |-> reg_rd_data == 16'h0000) else $error("bad read");
    chk_mux_follow: assert property (v && reg_rd_data[12] |-> gp_pin_zero_oe && gp_pin_one_oe
        && {gp_pin_one_out, gp_pin_zero_out} == $past(seq_channel_index)) else $error("mux");
    chk_mux_off: assert property (v && !reg_rd_data[12] |-> !gp_pin_zero_oe && !gp_pin_one_oe
        && !seq_limit_four) else $error("mux off");
    chk_limit_four: assert property (v && reg_rd_data[12] |-> seq_limit_four) else $error("lim");
    chk_od_drive: assert property (v && m == 2'h2 |-> !sync_err_out
        && sync_err_oe == $past(|status_error_bits)) else $error("open drain");
    chk_gp_drive: assert property (v && m == 2'h3 |-> sync_err_oe
        && sync_err_out == reg_rd_data[8]) else $error("gp out");
    chk_pin_input: assert property (v && m < 2'h2 |-> !sync_err_oe) else $error("pin oe");
    chk_err_nosync: assert property (v && (m != 2'h0 || !reg_rd_data[11])
        |-> !filter_hold_reset) else $error("hold");
    chk_start_pulse: assert property (conv_start |-> s_pulse) else $error("start");
    chk_wait_cause: assert property ($rose(conv_wait) |-> $past(seq_switch_due))
        else $error("wait");
endmodule
bind sepc_top sepc_checker #(.ERR_BITS(ERR_BITS)) CHK (.sys_clk, .sys_rst, .reg_addr,
    .reg_rd_data, .seq_channel_index, .seq_switch_due, .status_error_bits, .sync_err_out,
    .sync_err_oe, .gp_pin_zero_out, .gp_pin_zero_oe, .gp_pin_one_out, .gp_pin_one_oe,
    .filter_hold_reset, .conv_start, .conv_wait, .seq_limit_four);

// ===== sepc_pin_model.sv
// Sync/error wire: pull-up shared with another device that may pull it low.
// Assumes the pin control drives out and oe from the system clock.
`timescale 1ns/1ps
module sepc_pin_model (
    input wire sync_err_out,
    input wire sync_err_oe,
    input wire pull_low,
    output wire pin
);
    // Released line rises through the pull-up
    assign pin = (sync_err_oe ? sync_err_out : 1'b1) & ~pull_low;
endmodule

// ===== sync_error_pin_control_bench.sv
// Self-checking bench of the pin control through its register port.
// Assumes inputs change on the falling edge.
`timescale 1ns/1ps
module sync_error_pin_control_bench;
    reg sys_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg [5:0] reg_addr = 6'h06;
    reg reg_wr_en = 1'b0;
    reg [15:0] reg_wr_data = 16'h0000;
    reg alternate_sync_select_select = 1'b0;
    reg seq_multi_channel = 1'b0;
    reg [1:0] seq_channel_index = 2'h0;
    reg seq_switch_due = 1'b0;
    reg [15:0] mux_settle_cycles = 16'h0000;
    reg other_error = 1'b0;
    reg [3:0] status_error_bits = 4'h0;
    reg pull_low = 1'b0;
    wire [15:0] reg_rd_data;
    wire sync_err_in, sync_err_out, sync_err_oe, gp_pin_zero_out, gp_pin_zero_oe;
    wire gp_pin_one_out, gp_pin_one_oe, filter_hold_reset, conv_start, conv_wait;
    wire conv_error_flag, seq_limit_four;
    integer errors = 0;
    integer n_compared = 0;
    integer k;
    integer i;
    always #5 sys_clk = ~sys_clk;
    sepc_top DUT (.sys_clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_data,
        .alternate_sync_select_select, .seq_multi_channel, .seq_channel_index, .seq_switch_due,
        .mux_settle_cycles, .other_error, .status_error_bits, .sync_err_in, .sync_err_out,
        .sync_err_oe, .gp_pin_zero_out, .gp_pin_zero_oe, .gp_pin_one_out, .gp_pin_one_oe,
        .filter_hold_reset, .conv_start, .conv_wait, .conv_error_flag, .seq_limit_four);
    sepc_pin_model PIN (.sync_err_out, .sync_err_oe, .pull_low, .pin(sync_err_in));
    task complete_run;
        begin
            $display("errors=%0d n_compared=%0d", errors, n_compared);
            if (errors == 0 && n_compared > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(negedge sys_clk);
    endtask
    task wr(input [5:0] a, input [15:0] d);
        begin
            @(negedge sys_clk) reg_addr = a;
            reg_wr_en = 1'b1;
            reg_wr_data = d;
            @(negedge sys_clk) reg_wr_en = 1'b0;
        end
    endtask
    task rd(input [5:0] a, input [15:0] e);
        begin
            @(negedge sys_clk) reg_addr = a;
            @(negedge sys_clk) chk(reg_rd_data, e);
        end
    endtask
    // Counts falling edges from the due pulse, or from releasing a held pin
    task sw(input [15:0] e, input hold);
        begin
            @(negedge sys_clk) seq_switch_due = 1'b1;
            @(negedge sys_clk) seq_switch_due = 1'b0;
            k = 1;
            if (hold) begin
                cyc(6);
                chk({15'h0000, conv_wait}, 16'h0001);
                pull_low = 1'b0;
                k = 0;
            end
            while (conv_start !== 1'b1 && k < 40) begin
                @(negedge sys_clk);
                k = k + 1;
            end
            chk(k[15:0], e);
        end
    endtask
    initial begin
        #100000;
        errors = errors + 1;
        complete_run;
    end
    initial begin
        cyc(4);
        sys_rst = 1'b0;
        rd(6'h06, 16'h0900);
        wr(6'h05, 16'hffff);
        rd(6'h05, 16'h0000);
        rd(6'h06, 16'h0900);
        wr(6'h06, 16'hffff);
        rd(6'h06, 16'h1f00);
        chk({14'h0000, sync_err_oe, sync_err_out}, 16'h0003);
        for (i = 0; i < 4; i = i + 1) begin
            seq_channel_index = i[1:0];
            cyc(2);
            chk({gp_pin_one_oe, gp_pin_zero_oe, gp_pin_one_out, gp_pin_zero_out},
                16'h000c + i[15:0]);
            chk({15'h0000, seq_limit_four}, 16'h0001);
        end
        wr(6'h06, 16'h1e00);
        cyc(1);
        chk({14'h0000, sync_err_oe, sync_err_out}, 16'h0002);
        wr(6'h06, 16'h0800);
        pull_low = 1'b1;
        cyc(4);
        chk({15'h0000, filter_hold_reset}, 16'h0001);
        rd(6'h06, 16'h0800);
        pull_low = 1'b0;
        cyc(4);
        chk({15'h0000, filter_hold_reset}, 16'h0000);
        alternate_sync_select_select = 1'b1;
        pull_low = 1'b1;
        cyc(4);
        chk({15'h0000, filter_hold_reset}, 16'h0001);
        seq_multi_channel = 1'b1;
        cyc(2);
        chk({15'h0000, filter_hold_reset}, 16'h0000);
        sw(16'h0003, 1'b1);
        alternate_sync_select_select = 1'b0;
        wr(6'h06, 16'h0a00);
        pull_low = 1'b1;
        cyc(4);
        chk({14'h0000, conv_error_flag, filter_hold_reset}, 16'h0002);
        rd(6'h06, 16'h0a00);
        pull_low = 1'b0;
        cyc(4);
        chk({15'h0000, conv_error_flag}, 16'h0000);
        other_error = 1'b1;
        cyc(2);
        chk({15'h0000, conv_error_flag}, 16'h0001);
        other_error = 1'b0;
        wr(6'h06, 16'h0c00);
        status_error_bits = 4'h8;
        cyc(2);
        chk({13'h0000, sync_err_oe, sync_err_out, sync_err_in}, 16'h0004);
        status_error_bits = 4'h0;
        cyc(2);
        chk({14'h0000, sync_err_oe, sync_err_in}, 16'h0001);
        wr(6'h06, 16'h0000);
        pull_low = 1'b1;
        cyc(4);
        chk({14'h0000, conv_error_flag, filter_hold_reset}, 16'h0000);
        pull_low = 1'b0;
        wr(6'h06, 16'h1000);
        mux_settle_cycles = 16'h0003;
        sw(16'h0004, 1'b0);
        mux_settle_cycles = 16'h0000;
        sw(16'h0001, 1'b0);
        complete_run;
    end
endmodule
